// File: design/irem_error_mask.sv
// Device-specific error status, mask and interrupt block behind an APB slave.
//
// Functional notes
// - Mask bit 0 gates completion queue overflow.
// - Bits 1,2 gate egress soft-error counter overflows.
// - Bits 3,4 gate egress uncorrectable ECC errors.
// - Bit 5 gates ingress packet single-bit error.
// - Bits 6,7 gate egress allocation unit errors.
// - Bit 8 gates ingress packet uncorrectable error.
// - Bit 9 gates ingress list single-bit error.
// - Bit 10 gates ingress list uncorrectable error.
// - Bit 11 gates credit update timeout.
// - Bit 12 gates ingress credit underrun.
// - Bit 13 gates ingress allocation single-bit overflow.
// - Bit 14 gates ingress allocation two-bit error.
// - Mask bits sticky, EEPROM loadable, reset to one.
// - Error logging active by default.
// - Status flags sticky, write one clears, interrupt.
// - Egress soft-error counters overflow at 256.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module irem_error_mask (
  input  wire logic                          ref_clk,     // Core clock, 25 MHz.
  input  wire logic                          reset,       // Synchronous, active high.
  input  wire logic                          hot_reset,   // Clears non-sticky state only.
  input  wire logic                          psel,        // APB select.
  input  wire logic                          penable,     // APB access phase.
  input  wire logic                          pwrite,      // APB direction.
  input  wire logic [11:0]                   paddr,       // APB byte address.
  input  wire logic [31:0]                   pwdata,      // APB write data.
  input  wire logic [3:0]                    pstrb,       // APB byte strobes.
  output logic                               pready,      // APB ready, registered.
  output logic      [31:0]                   prdata,      // APB read data, registered.
  output logic                               pslverr,     // Unmapped address.
  input  wire irem_pkg::irem_events_type     err_events,  // Error pulses, same clock.
  input  wire irem_pkg::irem_eeprom_load_type eeprom_load, // Serial EEPROM loader.
  output logic                               irq          // Level error interrupt.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [14:0]                      status;
  logic [14:0]                      mask;
  logic                             int_enable;
  irem_pkg::irem_apb_state_type     apb_state;
  logic [7:0]                       pkt_count;
  logic [7:0]                       list_count;
  logic                             pkt_ovf;
  logic                             list_ovf;
  logic [14:0]                      set_vec;
  logic [14:0]                      pending;
  logic [14:0]                      lane_mask;
  logic                             access;
  logic                             commit;
  logic                             wr_commit;
  logic                             addr_hit;
  logic [31:0]                      read_word;
  logic                             ee_status;
  logic                             ee_mask;
  logic                             ee_control;

  // ---------------------------------------------------------------------------
  // Soft error counters
  // ---------------------------------------------------------------------------
  // Single-bit errors in the egress RAMs are counted; only the overflow of
  // each counter reaches the status register.
  irem_soft_err_counter #(
    .COUNT_WIDTH    (irem_pkg::SOFT_COUNT_WIDTH)
  ) u_pkt_counter (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .err_pulse      (err_events.egress_pkt_single_bit),
    .count          (pkt_count),
    .overflow_pulse (pkt_ovf)
  );

  irem_soft_err_counter #(
    .COUNT_WIDTH    (irem_pkg::SOFT_COUNT_WIDTH)
  ) u_list_counter (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .err_pulse      (err_events.egress_list_single_bit),
    .count          (list_count),
    .overflow_pulse (list_ovf)
  );

  // ---------------------------------------------------------------------------
  // Event mapping and gating
  // ---------------------------------------------------------------------------
  // Every source sets its flag whatever the mask says; the mask only decides
  // whether a set flag is reported.
  always_comb
  begin
    set_vec = 15'(err_events);
    set_vec[irem_pkg::EGR_PKT_OVF_BIT]  = pkt_ovf;
    set_vec[irem_pkg::EGR_LIST_OVF_BIT] = list_ovf;
  end

  // One mask bit per status bit, a one hides the flag from the interrupt.
  assign pending = status & ~mask;
  // Strobe 0 gates bits 0 to 7, strobe 1 gates bits 8 to 14.
  assign lane_mask = {{7{pstrb[1]}}, {8{pstrb[0]}}};

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  assign access    = psel && penable;
  assign commit    = access && pready;
  assign wr_commit = commit && pwrite;

  assign ee_status  = eeprom_load.valid && (eeprom_load.addr == irem_pkg::STATUS_OFFSET);
  assign ee_mask    = eeprom_load.valid && (eeprom_load.addr == irem_pkg::MASK_OFFSET);
  assign ee_control = eeprom_load.valid && (eeprom_load.addr == irem_pkg::CONTROL_OFFSET);

  // Address decode and read mux; reserved bits come back as zero.
  always_comb
  begin
    read_word = '0;
    addr_hit  = 1'b1;
    if (paddr == irem_pkg::STATUS_OFFSET)
    begin
      read_word[14:0] = status;
    end
    else if (paddr == irem_pkg::MASK_OFFSET)
    begin
      read_word[14:0] = mask;
    end
    else if (paddr == irem_pkg::CONTROL_OFFSET)
    begin
      read_word[irem_pkg::CTRL_INT_EN_BIT] = int_enable;
    end
    else if (paddr == irem_pkg::COUNT_OFFSET)
    begin
      read_word[irem_pkg::PKT_COUNT_LSB +: 8]  = pkt_count;
      read_word[irem_pkg::LIST_COUNT_LSB +: 8] = list_count;
    end
    else
    begin
      addr_hit = 1'b0;
    end
  end

  // Every access takes one wait state, so ready and read data both come from
  // flip-flops; the write lands on the edge where ready is seen high.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      apb_state <= irem_pkg::APB_WAIT;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end
    else
    begin
      case (apb_state)
        irem_pkg::APB_WAIT:
        begin
          if (access)
          begin
            pready    <= 1'b1;
            pslverr   <= ~addr_hit;
            prdata    <= pwrite ? 32'h00000000 : read_word;
            apb_state <= irem_pkg::APB_DONE;
          end
        end
        irem_pkg::APB_DONE:
        begin
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          prdata    <= 32'h00000000;
          apb_state <= irem_pkg::APB_WAIT;
        end
        default:
        begin
          apb_state <= irem_pkg::APB_WAIT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------------------
  // Sticky flags: only the full reset clears them, not hot_reset. A new event
  // in the same cycle as a write-one-to-clear survives the clear.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      status <= irem_pkg::STATUS_RESET;
    end
    else if (ee_status)
    begin
      status <= eeprom_load.data[14:0] | set_vec;
    end
    else if (wr_commit && paddr == irem_pkg::STATUS_OFFSET)
    begin
      status <= (status & ~(pwdata[14:0] & lane_mask)) | set_vec;
    end
    else
    begin
      status <= status | set_vec;
    end
  end

  // ---------------------------------------------------------------------------
  // Mask register
  // ---------------------------------------------------------------------------
  // Sticky as well; the EEPROM loader wins over a bus write in the same cycle
  // because it only runs before software owns the device.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mask <= irem_pkg::MASK_RESET;
    end
    else if (ee_mask)
    begin
      mask <= eeprom_load.data[14:0];
    end
    else if (wr_commit && paddr == irem_pkg::MASK_OFFSET)
    begin
      mask <= (mask & ~lane_mask) | (pwdata[14:0] & lane_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // The interrupt enable is ordinary state, so a hot reset restores it.
  always_ff @(posedge ref_clk)
  begin
    if (reset || hot_reset)
    begin
      int_enable <= irem_pkg::CTRL_INT_EN_RESET;
    end
    else if (ee_control)
    begin
      int_enable <= eeprom_load.data[irem_pkg::CTRL_INT_EN_BIT];
    end
    else if (wr_commit && paddr == irem_pkg::CONTROL_OFFSET && pstrb[0])
    begin
      int_enable <= pwdata[irem_pkg::CTRL_INT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt output
  // ---------------------------------------------------------------------------
  // Registered for a clean output; it lags the flag by one cycle.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= int_enable && (pending != 15'h0000);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_IRQ_UNMASKED:
    assert property (int_enable && (pending != 15'h0000) |=> irq)
    else $error("Unmasked set flag did not raise the interrupt.");

  AST_IRQ_MASKED:
    assert property ((pending == 15'h0000) || !int_enable |=> !irq)
    else $error("Interrupt raised with every flag masked or disabled.");

  AST_MASK_RESET:
    assert property (@(posedge ref_clk) disable iff (1'b0)
      reset |=> reset || (mask == irem_pkg::MASK_RESET))
    else $error("Mask did not reset to all ones.");

  AST_MASK_WRITE:
    assert property (wr_commit && paddr == irem_pkg::MASK_OFFSET && pstrb == 4'hF && !ee_mask
      |=> mask == $past(pwdata[14:0]))
    else $error("Mask write did not take effect.");

  AST_SET_WINS:
    assert property ((set_vec != 15'h0000) && !ee_status
      |=> (status & $past(set_vec)) == $past(set_vec))
    else $error("Error event lost or masked out of the status.");

  AST_W1C:
    assert property (wr_commit && paddr == irem_pkg::STATUS_OFFSET && pstrb == 4'hF
      && !ee_status && set_vec == 15'h0000
      |=> (status & $past(pwdata[14:0])) == 15'h0000)
    else $error("Write of one did not clear a status flag.");

  AST_OVERFLOW_256:
    assert property (err_events.egress_pkt_single_bit && pkt_count == 8'hFF
      |=> ##1 status[irem_pkg::EGR_PKT_OVF_BIT])
    else $error("Packet counter overflow did not set its flag.");

  AST_RSVD_ZERO:
    assert property (access && !pready && !pwrite && paddr == irem_pkg::MASK_OFFSET
      |=> pready && prdata[31:15] == 17'h00000)
    else $error("Reserved mask bits did not read zero.");

  AST_APB_ANSWER:
    assert property (access && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access.");

  COV_IRQ: cover property (!irq ##1 irq);
  COV_W1C_RACE: cover property (wr_commit && paddr == irem_pkg::STATUS_OFFSET
    && set_vec != 15'h0000);
  COV_OVERFLOW: cover property (pkt_ovf);
  COV_SLVERR: cover property (pslverr);

endmodule : irem_error_mask

`default_nettype wire

// File: design/irem_pkg.sv
// Shared constants and carrier types for the internal RAM error mask block.
package irem_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned      APB_ADDR_WIDTH = 12;
  localparam int unsigned      APB_DATA_WIDTH = 32;
  localparam logic [11:0]      STATUS_OFFSET  = 12'h1CC;
  localparam logic [11:0]      MASK_OFFSET    = 12'h1D0;
  localparam logic [11:0]      CONTROL_OFFSET = 12'h1D4;
  localparam logic [11:0]      COUNT_OFFSET   = 12'h1D8;

  // ---------------------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned      NUM_SOURCES        = 15;
  localparam logic [14:0]      MASK_RESET         = 15'h7FFF;
  localparam logic [14:0]      STATUS_RESET       = 15'h0000;
  localparam int unsigned      EGR_PKT_OVF_BIT    = 1;
  localparam int unsigned      EGR_LIST_OVF_BIT   = 2;
  localparam int unsigned      CTRL_INT_EN_BIT    = 0;
  localparam logic             CTRL_INT_EN_RESET  = 1'b1;
  localparam int unsigned      SOFT_COUNT_WIDTH   = 8;
  localparam int unsigned      PKT_COUNT_LSB      = 0;
  localparam int unsigned      LIST_COUNT_LSB     = 8;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Field order runs from status bit 14 down to bit 0, so a cast maps each
  // source straight onto its status and mask bit.
  typedef struct packed {
    logic ingress_alloc_double_bit;   // Bit 14.
    logic ingress_alloc_single_ovf;   // Bit 13.
    logic ingress_credit_underrun;    // Bit 12.
    logic credit_update_timeout;      // Bit 11.
    logic ingress_list_double_bit;    // Bit 10.
    logic ingress_list_single_bit;    // Bit 9.
    logic ingress_pkt_double_bit;     // Bit 8.
    logic egress_alloc_double_bit;    // Bit 7.
    logic egress_alloc_single_ovf;    // Bit 6.
    logic ingress_pkt_single_bit;     // Bit 5.
    logic egress_list_double_bit;     // Bit 4.
    logic egress_pkt_double_bit;      // Bit 3.
    logic egress_list_single_bit;     // Bit 2, counted before it sets a flag.
    logic egress_pkt_single_bit;      // Bit 1, counted before it sets a flag.
    logic cpl_queue_overflow;         // Bit 0.
  } irem_events_type;

  // One word pushed by the serial EEPROM loader.
  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [31:0] data;
  } irem_eeprom_load_type;

  typedef enum logic {
    APB_WAIT = 1'b0,
    APB_DONE = 1'b1
  } irem_apb_state_type;

endpackage : irem_pkg

// File: design/irem_soft_err_counter.sv
// Saturating single-bit soft error counter with an overflow event.
`timescale 1ns/1ps
`default_nettype none

module irem_soft_err_counter #(
  parameter int unsigned COUNT_WIDTH = 8
) (
  input  wire logic                   ref_clk,       // Core clock.
  input  wire logic                   reset,         // Synchronous, active high.
  input  wire logic                   err_pulse,     // One corrected error.
  output logic      [COUNT_WIDTH-1:0] count,         // Errors seen, saturating.
  output logic                        overflow_pulse // Count has reached 2**WIDTH.
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  if (COUNT_WIDTH < 1 || COUNT_WIDTH > 8)
  begin : g_width_check
    $error("COUNT_WIDTH must lie between 1 and 8.");
  end

  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = '1;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = COUNT_WIDTH'(1);

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // The counter holds at its top value; an error arriving there is the one
  // that takes the total to 2**WIDTH, and every later one still overflows.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count          <= '0;
      overflow_pulse <= 1'b0;
    end
    else
    begin
      overflow_pulse <= err_pulse && (count == COUNT_MAX);
      if (err_pulse && (count != COUNT_MAX))
      begin
        count <= count + COUNT_ONE;
      end
    end
  end

endmodule : irem_soft_err_counter

`default_nettype wire

// File: dv/irem_error_mask_tb.sv
// Self-checking testbench for the internal RAM error mask block.
`timescale 1ns/1ps
`default_nettype none

module irem_error_mask_tb;
  logic                              ref_clk     = 1'b0; // Core clock.
  logic                              reset       = 1'b1; // Synchronous reset.
  logic                              hot_reset   = 1'b0; // Non-sticky reset.
  logic                              psel        = 1'b0; // APB select.
  logic                              penable     = 1'b0; // APB enable.
  logic                              pwrite      = 1'b0; // APB direction.
  logic [11:0]                       paddr       = 12'h000; // APB address.
  logic [31:0]                       pwdata      = 32'h0; // APB write data.
  logic [3:0]                        pstrb       = 4'hF; // APB strobes.
  logic                              pready;       // APB ready.
  logic [31:0]                       prdata;       // APB read data.
  logic                              pslverr;      // APB error.
  irem_pkg::irem_events_type         err_events  = '0; // Error pulses.
  irem_pkg::irem_eeprom_load_type    eeprom_load = '0; // Loader port.
  logic                              irq;          // Interrupt level.
  int                                n_errors    = 0;
  int                                checked     = 0;
  logic [31:0]                       rd;
  logic                              er;
  logic [14:0]                       row_ev   [30];
  logic [14:0]                       row_mask [30];
  logic                              row_irq  [30];

  // ---------------------------------------------------------------------------
  // Clock and design instance
  // ---------------------------------------------------------------------------
  // Half period of 20 ns gives the 25 MHz core clock.
  always #20 ref_clk = ~ref_clk;

  irem_error_mask irem_error_mask_i (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .hot_reset   (hot_reset),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pstrb       (pstrb),
    .pready      (pready),
    .prdata      (prdata),
    .pslverr     (pslverr),
    .err_events  (err_events),
    .eeprom_load (eeprom_load),
    .irq         (irq)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d.", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Holds the given events high for the given number of cycles.
  task automatic pulse(input logic [14:0] v, input int cycles);
    @(posedge ref_clk);
    err_events <= irem_pkg::irem_events_type'(v);
    repeat (cycles) @(posedge ref_clk);
    err_events <= '0;
  endtask : pulse

  task automatic do_reset;
    reset <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask : do_reset

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    // Each source alone, first unmasked and then masked; the egress
    // soft-error sources need 256 errors, so one pulse must not flag them.
    for (int k = 0; k < 30; k++)
    begin
      row_ev[k]   = 15'h0001 << (k % 15);
      row_mask[k] = (k < 15) ? ~row_ev[k] : 15'h7FFF;
      row_irq[k]  = (k < 15) && ((k % 15) != 1) && ((k % 15) != 2);
    end
    do_reset();
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, irem_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h0000_7FFF);
    apb(1'b0, irem_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, irem_pkg::CONTROL_OFFSET, 32'h0);
    chk(rd, 32'h1);
    $display("Test reset values done.");

    for (int k = 0; k < 30; k++)
    begin
      apb(1'b1, irem_pkg::MASK_OFFSET, {17'h0, row_mask[k]});
      pulse(row_ev[k], 1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, {31'h0, row_irq[k]});
      apb(1'b0, irem_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, {17'h0, row_ev[k] & 15'h7FF9});
      apb(1'b1, irem_pkg::STATUS_OFFSET, 32'h0000_7FFF);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("Test per-source masking done.");

    // Reserved bits read zero and ignore writes.
    apb(1'b1, irem_pkg::MASK_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, irem_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h0000_7FFF);
    apb(1'b1, irem_pkg::MASK_OFFSET, 32'hFFFF_8000);
    apb(1'b0, irem_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h1E0, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("Test reserved and unmapped done.");

    // A set flag stays set; the enable gates the interrupt.
    apb(1'b1, irem_pkg::MASK_OFFSET, 32'h0000_7FFE);
    pulse(15'h0001, 1);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, irem_pkg::CONTROL_OFFSET, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, irem_pkg::CONTROL_OFFSET, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, irem_pkg::STATUS_OFFSET, 32'h0000_0001);
    $display("Test interrupt enable done.");

    // The mask survives a hot reset; the loader can set the mask.
    apb(1'b1, irem_pkg::MASK_OFFSET, 32'h0000_1234);
    @(posedge ref_clk);
    hot_reset <= 1'b1;
    @(posedge ref_clk);
    hot_reset <= 1'b0;
    apb(1'b0, irem_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h0000_1234);
    @(posedge ref_clk);
    eeprom_load <= '{valid: 1'b1, addr: irem_pkg::MASK_OFFSET, data: 32'h0000_0ABC};
    @(posedge ref_clk);
    eeprom_load <= '0;
    apb(1'b0, irem_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h0000_0ABC);
    $display("Test sticky and loader done.");

    // The 256th corrected error sets the overflow flag, not the 255th.
    do_reset();
    apb(1'b1, irem_pkg::MASK_OFFSET, 32'h0000_7FF9);
    pulse(15'h0006, 255);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, irem_pkg::COUNT_OFFSET, 32'h0);
    chk(rd, 32'h0000_FFFF);
    apb(1'b0, irem_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pulse(15'h0006, 1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, irem_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0000_0006);
    $display("Test counter overflow done.");
    close_out();
  end
endmodule : irem_error_mask_tb

`default_nettype wire
